// file: hdl/dcorb_bank.sv
// Overview of operation
// - Upper-word register bits 15:11 read zero.
// - Pull-range bits 15:4 read zero, ignored.
// - Bit 10 software output enable, reset 0.
// - Hardware enable mode ignores enable writes.
// - Steer word: 10 upper, 16 lower.
// - Steer word is signed two's complement.
// - Steer word resets to zero.
// - New steer applies on upper-word write.
// - Four-bit code selects pull span.
// - Pull range starts factory value, writable.
// - Bits 15:11 hold divider integer.
// - Bits 10:0 hold upper fraction bits.
// - Divider fields factory reset, host writable.
// - Lower fraction word in next register.
module dcorb_bank
    import dcorb_pkg::*;
#(
    parameter logic [3:0]  FACTORY_RANGE = DCORB_RST_RANGE,
    parameter logic [15:0] FACTORY_FBDIV = DCORB_RST_FBDIV
) (
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire dcorb_req_t          req,
    input  wire logic                oe_sw_mode,
    output logic        [15:0]       rdata,
    output logic                     rvalid,
    output logic                     out_enable,
    output logic signed [25:0]       steer,
    output logic                     steer_update,
    output logic        [3:0]        pull_range,
    output logic        [4:0]        fb_int,
    output logic        [26:0]       fb_frac
);
    logic        [15:0] steer_lo;
    logic        [15:0] frac_lo;
    logic        [15:0] mem_rdata;
    logic               oe_bit;
    logic        [9:0]  steer_hi;
    logic        [3:0]  range_q;
    logic        [15:0] fbdiv_q;
    logic        [2:0]  rd_addr_q;
    logic               rd_q;
    dcorb_state_t       state;
    dcorb_state_t       next_state;

    function automatic logic hit(input dcorb_req_t r, input logic [2:0] a);
        return r.wr && (r.addr == a);
    endfunction : hit

    wire wr_upper = hit(req, DCORB_ADDR_OE_STEER);
    wire wr_range = hit(req, DCORB_ADDR_RANGE);
    wire wr_fbdiv = hit(req, DCORB_ADDR_FBDIV);
    wire mem_we   = hit(req, DCORB_ADDR_STEER_LO) || hit(req, DCORB_ADDR_FRAC_LO);

    // lower words live in the small store
    dcorb_regmem u_mem (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .we       (mem_we),
        .waddr    (req.addr),
        .wdata    (req.wdata),
        .raddr    (req.addr),
        .rdata    (mem_rdata),
        .steer_lo (steer_lo),
        .frac_lo  (frac_lo)
    );

    wire [15:0] upper_rd = {5'h00, oe_bit, steer_hi};
    wire [15:0] range_rd = {12'h000, range_q};
    wire        rd_mem   = (rd_addr_q == DCORB_ADDR_STEER_LO) || (rd_addr_q == DCORB_ADDR_FRAC_LO);
    wire [15:0] next_rdata = rd_mem                               ? mem_rdata :
                             (rd_addr_q == DCORB_ADDR_OE_STEER)   ? upper_rd  :
                             (rd_addr_q == DCORB_ADDR_RANGE)      ? range_rd  :
                             (rd_addr_q == DCORB_ADDR_FBDIV)      ? fbdiv_q   : 16'h0000;

    wire next_oe = (wr_upper && oe_sw_mode) ? req.wdata[DCORB_OE_BIT] : oe_bit;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_bit    <= 1'b0;
            steer_hi  <= 10'h000;
            range_q   <= FACTORY_RANGE;
            fbdiv_q   <= FACTORY_FBDIV;
            rd_addr_q <= 3'h0;
            rd_q      <= 1'b0;
        end else begin
            oe_bit    <= next_oe;
            if (wr_upper) begin
                steer_hi <= req.wdata[9:0];
            end
            if (wr_range) begin
                range_q <= req.wdata[3:0];
            end
            if (wr_fbdiv) begin
                fbdiv_q <= req.wdata;
            end
            rd_addr_q <= req.addr;
            rd_q      <= req.rd;
        end
    end

    // commit one cycle after upper write
    always_comb begin
        next_state = DCORB_IDLE;
        case (state)
            DCORB_IDLE:   next_state = wr_upper ? DCORB_COMMIT : DCORB_IDLE;
            DCORB_COMMIT: next_state = wr_upper ? DCORB_COMMIT : DCORB_IDLE;
            default:      next_state = DCORB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= DCORB_IDLE;
            steer        <= '0;
            steer_update <= 1'b0;
            out_enable   <= 1'b0;
            pull_range   <= FACTORY_RANGE;
            fb_int       <= FACTORY_FBDIV[15:11];
            fb_frac      <= {FACTORY_FBDIV[10:0], DCORB_RST_FRAC_LO};
            rdata        <= 16'h0000;
            rvalid       <= 1'b0;
        end else begin
            state        <= next_state;
            steer_update <= (state == DCORB_COMMIT);
            if (state == DCORB_COMMIT) begin
                steer <= signed'({steer_hi, steer_lo});
            end
            out_enable   <= oe_bit;
            pull_range   <= range_q;
            fb_int       <= fbdiv_q[15:11];
            fb_frac      <= {fbdiv_q[10:0], frac_lo};
            rvalid       <= rd_q;
            if (rd_q) begin
                rdata <= next_rdata;
            end
        end
    end

    property p_steer_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        (state == DCORB_IDLE) |=> $stable(steer);
    endproperty
    a_steer_hold_idle: assert property (p_steer_hold) else $error("steer changed without commit");

    sequence s_upper_wr;
        wr_upper;
    endsequence
    sequence s_commit;
        ##1 (state == DCORB_COMMIT) ##1 (steer == signed'({$past(steer_hi), $past(steer_lo)}));
    endsequence
    a_steer_commit_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_upper_wr |-> s_commit) else $error("steer not loaded after upper write");

    // Lower word written while no commit is pending
    sequence s_lower_wr_idle;
        req.wr && (req.addr == DCORB_ADDR_STEER_LO) && (state == DCORB_IDLE);
    endsequence
    a_lower_wr_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_lower_wr_idle |=> ##1 $stable(steer)) else $error("lower word write moved steer");

    a_steer_update_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state == DCORB_COMMIT) |=> steer_update) else $error("steer update pulse missing");

    a_steer_update_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state == DCORB_IDLE) |=> !steer_update) else $error("steer update without commit");

    a_steer_sign: assert property (@(posedge sys_clk) disable iff (!reset_n)
        steer_update |-> ((steer < 26'sd0) == $past(steer_hi[9]))) else $error("steer sign lost");

    a_oe_hw_ignore: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!oe_sw_mode) |=> $stable(oe_bit)) else $error("enable changed in hardware mode");

    a_oe_sw_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_upper && oe_sw_mode) |=> ##1 (out_enable == $past(req.wdata[DCORB_OE_BIT], 2)))
        else $error("enable write not reflected");

    a_upper_pad_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_q && rd_addr_q == DCORB_ADDR_OE_STEER) |=> (rdata[15:11] == 5'h00))
        else $error("upper word unused bits nonzero");

    a_upper_read_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_q && rd_addr_q == DCORB_ADDR_OE_STEER) |=> (rdata[10:0] == {$past(oe_bit), $past(steer_hi)}))
        else $error("upper word read wrong");

    a_range_pad_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_q && rd_addr_q == DCORB_ADDR_RANGE) |=> (rdata[15:4] == 12'h000))
        else $error("range unused bits nonzero");

    a_range_read_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_q && rd_addr_q == DCORB_ADDR_RANGE) |=> (rdata[3:0] == $past(range_q)))
        else $error("range read wrong");

    a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_q && rd_addr_q > DCORB_ADDR_FRAC_LO) |=> (rdata == 16'h0000))
        else $error("unmapped read nonzero");

    a_range_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_range |=> ##1 (pull_range == $past(req.wdata[3:0], 2)))
        else $error("range write lost");

    a_fbdiv_fields: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_fbdiv |=> ##1 (fb_int == $past(req.wdata[15:11], 2) && fb_frac[26:16] == $past(req.wdata[10:0], 2)))
        else $error("divider fields wrong");

    a_frac_lo_field: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (req.wr && req.addr == DCORB_ADDR_FRAC_LO) |=> ##1 (fb_frac[15:0] == $past(req.wdata, 2)))
        else $error("lower fraction field wrong");

    a_read_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
        req.rd |-> ##2 rvalid) else $error("read answer missing");
endmodule : dcorb_bank

// file: hdl/dcorb_pkg.sv
package dcorb_pkg;
    localparam int          DCORB_WORD_W       = 16;
    localparam int          DCORB_ADDR_W       = 3;
    localparam int          DCORB_STEER_W      = 26;
    localparam int          DCORB_STEER_HI_W   = 10;
    localparam int          DCORB_FRAC_W       = 27;
    localparam int          DCORB_FRAC_HI_W    = 11;
    localparam int          DCORB_INT_W        = 5;
    localparam int          DCORB_RANGE_W      = 4;
    localparam int          DCORB_NREG         = 5;

    // Register addresses
    localparam logic [2:0]  DCORB_ADDR_STEER_LO = 3'h0;
    localparam logic [2:0]  DCORB_ADDR_OE_STEER = 3'h1;
    localparam logic [2:0]  DCORB_ADDR_RANGE    = 3'h2;
    localparam logic [2:0]  DCORB_ADDR_FBDIV    = 3'h3;
    localparam logic [2:0]  DCORB_ADDR_FRAC_LO  = 3'h4;

    // Field positions
    localparam int          DCORB_OE_BIT        = 10;
    localparam int          DCORB_INT_LSB       = 11;

    // Reset values
    localparam logic [15:0] DCORB_RST_ZERO      = 16'h0000;
    localparam logic [3:0]  DCORB_RST_RANGE     = 4'h3;
    localparam logic [15:0] DCORB_RST_FBDIV     = 16'h0000;
    localparam logic [15:0] DCORB_RST_FRAC_LO   = 16'h0000;

    // Host access as one carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } dcorb_req_t;

    // Settings seen by the oscillator core
    typedef struct packed {
        logic        out_enable;
        logic [25:0] steer;
        logic [3:0]  pull_range;
        logic [4:0]  fb_int;
        logic [26:0] fb_frac;
    } dcorb_cfg_t;

    typedef enum logic [0:0] {
        DCORB_IDLE   = 1'b0,
        DCORB_COMMIT = 1'b1
    } dcorb_state_t;
endpackage : dcorb_pkg

// file: hdl/dcorb_regmem.sv
module dcorb_regmem
    import dcorb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [2:0]  raddr,
    output logic      [15:0] rdata,
    output logic      [15:0] steer_lo,
    output logic      [15:0] frac_lo
);
    // Plain word store for the two full-width lower words
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            steer_lo <= DCORB_RST_ZERO;
            frac_lo  <= DCORB_RST_FRAC_LO;
            rdata    <= DCORB_RST_ZERO;
        end else begin
            if (we && waddr == DCORB_ADDR_STEER_LO) begin
                steer_lo <= wdata;
            end
            if (we && waddr == DCORB_ADDR_FRAC_LO) begin
                frac_lo <= wdata;
            end
            rdata <= (raddr == DCORB_ADDR_STEER_LO) ? steer_lo : frac_lo;
        end
    end
endmodule : dcorb_regmem

// file: test/dcorb_host_model.sv
module dcorb_host_model
    import dcorb_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rvalid,
    input  wire logic [15:0] rdata,
    output dcorb_req_t       req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '{wr: 1'b0, rd: 1'b0, addr: 3'h0, wdata: 16'h0000};

    task automatic put(input logic w, input logic [2:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put

    task automatic get(input logic [2:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        put(1'b0, a, 16'h0000);
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge sys_clk);
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
            end
        end
    endtask : get
endmodule : dcorb_host_model

// file: test/dco_control_register_bank_tb.sv
module dco_control_register_bank_tb
    import dcorb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0]  F_RANGE = 4'h5;
    localparam logic [15:0] F_FBDIV = 16'hA5C3;

    logic               sys_clk;
    logic               reset_n;
    logic               oe_sw_mode;
    dcorb_req_t         req;
    logic        [15:0] rdata;
    logic               rvalid;
    logic               out_enable;
    logic signed [25:0] steer;
    logic               steer_update;
    logic        [3:0]  pull_range;
    logic        [4:0]  fb_int;
    logic        [26:0] fb_frac;
    logic        [15:0] rd_word;
    logic               ok;
    int                 fails = 0;
    int                 samples_checked = 0;
    int                 n_upd = 0;

    dcorb_bank #(.FACTORY_RANGE(F_RANGE), .FACTORY_FBDIV(F_FBDIV)) i_dcorb_bank (
        .sys_clk(sys_clk), .reset_n(reset_n), .req(req), .oe_sw_mode(oe_sw_mode),
        .rdata(rdata), .rvalid(rvalid), .out_enable(out_enable), .steer(steer),
        .steer_update(steer_update), .pull_range(pull_range), .fb_int(fb_int), .fb_frac(fb_frac));

    dcorb_host_model i_dcorb_host_model (.sys_clk(sys_clk), .rvalid(rvalid), .rdata(rdata), .req(req));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) if (steer_update === 1'b1) n_upd++;

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
        i_dcorb_host_model.get(a, rd_word, ok);
        if (!ok) begin
            fails++;
            $display("mismatch at %0t: no read answer", $time);
            final_report();
        end else begin
            check(rd_word, exp);
        end
    endtask : rchk

    // Write, then let the fields land
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        i_dcorb_host_model.put(1'b1, a, d);
        repeat (2) @(negedge sys_clk);
    endtask : wr

    initial begin
        reset_n = 1'b0;
        oe_sw_mode = 1'b1;
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        check(out_enable, 1'b0);
        check({6'h00, steer}, 32'h0);
        rchk(3'h1, 16'h0000);
        rchk(3'h2, {12'h000, F_RANGE});
        rchk(3'h3, F_FBDIV);
        check(pull_range, F_RANGE);
        check(fb_int, F_FBDIV[15:11]);
        check(fb_frac, {F_FBDIV[10:0], 16'h0000});
        wr(3'h0, 16'h1234);
        check({6'h00, steer}, 32'h0);
        check(n_upd, 0);
        rchk(3'h0, 16'h1234);
        wr(3'h1, 16'hFFFF);
        rchk(3'h1, 16'h07FF);
        check({6'h00, steer}, 32'h03FF1234);
        check(steer < 26'sd0, 1'b1);
        check(out_enable, 1'b1);
        check(n_upd, 1);
        oe_sw_mode = 1'b0;
        wr(3'h1, 16'h0000);
        check(out_enable, 1'b1);
        rchk(3'h1, 16'h0400);
        check({6'h00, steer}, 32'h00001234);
        oe_sw_mode = 1'b1;
        wr(3'h2, 16'hFFF7);
        rchk(3'h2, 16'h0007);
        for (int c = 3; c < 16; c++) begin
            wr(3'h2, 16'(c));
            check(pull_range, c[3:0]);
        end
        wr(3'h3, 16'h5A5A);
        wr(3'h4, 16'hBEEF);
        check(fb_int, 5'h0B);
        check(fb_frac, {11'h25A, 16'hBEEF});
        rchk(3'h3, 16'h5A5A);
        rchk(3'h4, 16'hBEEF);
        wr(3'h5, 16'hFFFF);
        rchk(3'h5, 16'h0000);
        reset_n = 1'b0;
        @(negedge sys_clk);
        reset_n = 1'b1;
        check(out_enable, 1'b0);
        check(pull_range, F_RANGE);
        rchk(3'h1, 16'h0000);
        final_report();
    end
endmodule : dco_control_register_bank_tb
